// ### etc_exception_ctrl.sv
// Function
// RL1: Reset halts the core at once, mid-instruction.
// RL2: After reset, fetch reset vector; privileged Thread.
// RL3: Reset unbanked; execution starts in Secure state.
// RL4: NMI comes from peripheral or software.
// RL5: Secure hard fault beats pending or active NMI (here with select 1 only; at select 0 it is -1 and NMI wins).
// RL6: NMI unbanked; select 0 Secure, 1 Non-secure.
// RL7: Hard fault on errors, fixed priority -1.
// RL8: Separate Secure/Non-secure fault, call, service, tick.
// RL9: Select 0 sends all faults to Secure.
// RL10: Select 1: Non-secure faults, bus faults Non-secure.
// RL11: Secure hard fault -3 only with select 1.
// RL12: Secure-origin non-bus faults go to Secure hard fault.
// RL13: Supervisor call raised when its instruction executes.
// RL14: Tick raised at timer zero or by software.
// RL15: Interrupts from peripherals or software, asynchronous.
// RL16: Interrupts unbanked, Secure-assignable, default Secure.
// RL17: Lower priority value wins arbitration.
// RL18: Pending on request, cleared at entry; active tracked.
module etc_exception_ctrl
   import etc_pkg::*;
#(
   parameter int N_IRQ = 32
) (
   // Clock and reset.
   input  wire logic             mclk_i,
   input  wire logic             reset_i,
   // Security configuration.
   input  wire logic             fault_nmi_nonsecure_select_i,
   input  wire logic             irq_target_we_i,
   input  wire logic [N_IRQ-1:0] irq_target_ns_i,
   // Exception requests.
   input  wire logic             nmi_periph_i,
   input  wire logic             nmi_soft_i,
   input  wire etc_fault_t       fault_i,
   input  wire logic             supervisor_call_i,
   input  wire logic [1:0]       pendable_service_request_i,
   input  wire logic [1:0]       tick_zero_i,
   input  wire logic [1:0]       tick_soft_i,
   input  wire logic [N_IRQ-1:0] irq_i,
   input  wire logic [N_IRQ-1:0] irq_soft_i,
   // Pipeline handshake, core control and status outputs.
   input  wire logic             boot_done_i,
   input  wire logic             take_ready_i,
   input  wire etc_ret_t         ret_i,
   output logic                  take_valid_o,
   output etc_take_t             take_o,
   output etc_core_t             core_o,
   output logic [N_IRQ-1:0]      irq_target_ns_o,
   output logic [N_IRQ+8:0]      pending_o,
   output logic [N_IRQ+8:0]      active_o
);

   localparam int NS  = ETC_SL_IRQ0 + N_IRQ;
   localparam int SLW = $clog2(NS);

   if (N_IRQ < 1 || N_IRQ > ETC_MAX_IRQ) begin : g_bad_irq
      $error("N_IRQ must lie between 1 and 240");
   end

   etc_boot_t        state_reg;
   logic             halt_reg;
   logic             secure_reg;
   logic [NS-1:0]    pend_reg;
   logic [NS-1:0]    act_reg;
   logic [N_IRQ-1:0] itns_reg;
   logic             take_valid_reg;
   logic [SLW-1:0]   take_slot_reg;
   etc_take_t        take_reg;
   logic             boot_reg;
   logic             handler_reg;

   logic             sel;
   logic             take_fire;
   logic [NS-1:0]    set_vec;
   logic [NS-1:0]    take_clr;
   logic [NS-1:0]    ret_clr;
   logic             best_found;
   logic [SLW-1:0]   best_slot;
   etc_prio_t        best_prio;
   etc_prio_t        exec_prio;
   logic [NS-1:0]    act_next;

   assign sel       = fault_nmi_nonsecure_select_i;
   assign take_fire = take_valid_reg & take_ready_i;
   assign act_next  = (act_reg & ~ret_clr) | take_clr;

   function automatic logic [7:0] slot_num(input int s);
      logic [7:0] n;
      n = ETC_EXC_IRQ0;
      case (s)
         ETC_SL_NMI: n = ETC_EXC_NMI;
         ETC_SL_HF_S, ETC_SL_HF_NS: n = ETC_EXC_HF;
         ETC_SL_SUP_S, ETC_SL_SUP_N: n = ETC_EXC_SUP;
         ETC_SL_PSV_S, ETC_SL_PSV_N: n = ETC_EXC_PSV;
         ETC_SL_TCK_S, ETC_SL_TCK_N: n = ETC_EXC_TCK;
         default: n = ETC_EXC_IRQ0 + 8'(s - ETC_SL_IRQ0);
      endcase
      return n;
   endfunction

   // The Secure hard fault slot doubles as the single hard fault when the
   // select field is 0, so its priority follows the field.
   function automatic etc_prio_t slot_prio(input int s, input logic f);
      etc_prio_t p;
      p = ETC_PRIO_CFG;
      case (s)
         ETC_SL_NMI: p = ETC_PRIO_NMI;
         ETC_SL_HF_S: p = (f == ETC_SEL_NONSEC) ? ETC_PRIO_SHF : ETC_PRIO_HF; // RL11 RL5
         ETC_SL_HF_NS: p = ETC_PRIO_HF; // RL7
         default: p = ETC_PRIO_CFG;
      endcase
      return p;
   endfunction

   function automatic logic slot_secure(input int s, input logic f,
                                        input logic [N_IRQ-1:0] itns);
      logic r;
      r = 1'h1;
      case (s)
         ETC_SL_NMI: r = (f == ETC_SEL_SECURE); // RL6
         ETC_SL_HF_S, ETC_SL_SUP_S, ETC_SL_PSV_S, ETC_SL_TCK_S: r = 1'h1;
         ETC_SL_HF_NS, ETC_SL_SUP_N, ETC_SL_PSV_N, ETC_SL_TCK_N: r = 1'h0;
         default: r = ~itns[s - ETC_SL_IRQ0];
      endcase
      return r;
   endfunction

   // Requests. Every source is a one-cycle pulse from logic on mclk_i.
   always_comb begin
      set_vec = '0;
      set_vec[ETC_SL_NMI] = nmi_periph_i | nmi_soft_i; // RL4
      if (fault_i.valid) begin
         if (sel == ETC_SEL_SECURE) begin
            set_vec[ETC_SL_HF_S] = 1'h1; // RL9
         end else if (fault_i.secure_origin && !fault_i.bus_fault) begin
            set_vec[ETC_SL_HF_S] = 1'h1; // RL12
         end else begin
            set_vec[ETC_SL_HF_NS] = 1'h1; // RL10
         end
      end
      if (supervisor_call_i) begin
         if (secure_reg) begin
            set_vec[ETC_SL_SUP_S] = 1'h1; // RL13 RL8
         end else begin
            set_vec[ETC_SL_SUP_N] = 1'h1; // RL13 RL8
         end
      end
      set_vec[ETC_SL_PSV_S] = pendable_service_request_i[ETC_BANK_S]; // RL8
      set_vec[ETC_SL_PSV_N] = pendable_service_request_i[ETC_BANK_NS];
      set_vec[ETC_SL_TCK_S] = tick_zero_i[ETC_BANK_S] | tick_soft_i[ETC_BANK_S]; // RL14
      set_vec[ETC_SL_TCK_N] = tick_zero_i[ETC_BANK_NS] | tick_soft_i[ETC_BANK_NS];
      for (int i = 0; i < N_IRQ; i++) begin
         set_vec[ETC_SL_IRQ0 + i] = irq_i[i] | irq_soft_i[i]; // RL15
      end
   end

   // Handler entry clears pending; an exception return clears active.
   always_comb begin
      take_clr = '0;
      ret_clr  = '0;
      take_clr[take_slot_reg] = take_fire;
      if (ret_i.valid) begin
         if (ret_i.excnum >= ETC_EXC_IRQ0) begin
            for (int i = 0; i < N_IRQ; i++) begin
               if (ret_i.excnum == ETC_EXC_IRQ0 + 8'(i)) begin
                  ret_clr[ETC_SL_IRQ0 + i] = 1'h1;
               end
            end
         end else begin
            for (int s = 0; s < ETC_SL_IRQ0; s++) begin
               if (slot_num(s) == ret_i.excnum
                   && slot_secure(s, sel, itns_reg) == ret_i.exc_secure) begin
                  ret_clr[s] = 1'h1;
               end
            end
            if (ret_i.excnum == ETC_EXC_NMI) begin
               ret_clr[ETC_SL_NMI] = 1'h1;
            end
         end
      end
   end

   // A handler may only be entered above the running priority. The loop
   // runs upward with a strict compare, so ties go to the lower slot.
   always_comb begin
      exec_prio  = ETC_PRIO_THREAD;
      best_found = 1'h0;
      best_slot  = '0;
      best_prio  = ETC_PRIO_THREAD;
      for (int s = 0; s < NS; s++) begin
         if (act_reg[s] && slot_prio(s, sel) < exec_prio) begin
            exec_prio = slot_prio(s, sel);
         end
         if (pend_reg[s] && !take_clr[s] && slot_prio(s, sel) < best_prio) begin // RL17
            best_found = 1'h1;
            best_slot  = SLW'(s);
            best_prio  = slot_prio(s, sel);
         end
      end
   end

   // Set wins over clear, so a request in the entry cycle stays pending.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~take_clr) | set_vec; // RL18
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         act_reg <= '0;
      end else begin
         act_reg <= act_next; // RL18
      end
   end

   // The handler flag is its own flop, so the core sees a registered level
   // rather than a wide OR of the active vector.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         handler_reg <= 1'h0;
      end else begin
         handler_reg <= |act_next; // RL18
      end
   end

   // Only Secure code may retarget an interrupt.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         itns_reg <= '0; // RL16
      end else if (irq_target_we_i && secure_reg) begin
         itns_reg <= irq_target_ns_i; // RL16
      end
   end

   // The offered entry may be replaced by a better one while it waits.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         take_valid_reg <= 1'h0;
         take_slot_reg  <= '0;
         take_reg       <= '0;
      end else begin
         take_valid_reg <= (state_reg == ETC_RUN) && best_found
                           && (best_prio < exec_prio) && !take_fire;
         take_slot_reg  <= best_slot;
         take_reg.excnum <= slot_num(int'(best_slot));
         take_reg.secure <= slot_secure(int'(best_slot), sel, itns_reg);
         take_reg.prio   <= best_prio;
      end
   end

   // Halting is asynchronous so the core stops mid-instruction.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ETC_HALT; // RL1
         halt_reg  <= 1'h1; // RL1
         boot_reg  <= 1'h0;
      end else begin
         halt_reg <= 1'h0;
         case (state_reg)
            ETC_HALT: begin
               state_reg <= ETC_BOOT; // RL2
               boot_reg  <= 1'h1; // RL2
            end
            ETC_BOOT: begin
               if (boot_done_i) begin
                  state_reg <= ETC_RUN;
                  boot_reg  <= 1'h0;
               end
            end
            default: begin
               state_reg <= ETC_RUN;
               boot_reg  <= 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         secure_reg <= 1'h1; // RL3
      end else if (take_fire) begin
         secure_reg <= take_reg.secure;
      end else if (ret_i.valid) begin
         secure_reg <= ret_i.back_secure;
      end
   end

   assign take_valid_o    = take_valid_reg;
   assign take_o          = take_reg;
   assign irq_target_ns_o = itns_reg;
   assign pending_o       = pend_reg;
   assign active_o        = act_reg;

   // No control register is modelled, so execution is always privileged.
   always_comb begin
      core_o.halt       = halt_reg;
      core_o.boot_fetch = boot_reg; // RL2
      core_o.vec_off    = ETC_RESET_VEC_OFF;
      core_o.secure     = secure_reg;
      core_o.privileged = 1'h1; // RL2
      core_o.handler    = handler_reg;
   end

endmodule // etc_exception_ctrl

// ### etc_pkg.sv
package etc_pkg;

   // Fixed exception slots; peripheral interrupts follow from ETC_SL_IRQ0.
   localparam int ETC_SL_NMI   = 0;
   localparam int ETC_SL_HF_S  = 1;
   localparam int ETC_SL_HF_NS = 2;
   localparam int ETC_SL_SUP_S = 3;
   localparam int ETC_SL_SUP_N = 4;
   localparam int ETC_SL_PSV_S = 5;
   localparam int ETC_SL_PSV_N = 6;
   localparam int ETC_SL_TCK_S = 7;
   localparam int ETC_SL_TCK_N = 8;
   localparam int ETC_SL_IRQ0  = 9;
   localparam int ETC_MAX_IRQ  = 240;

   // Index of the Secure and Non-secure copy in two-bit request groups.
   localparam int ETC_BANK_NS = 0;
   localparam int ETC_BANK_S  = 1;

   // Values of the fault/NMI security-select field.
   localparam logic ETC_SEL_SECURE = 1'h0;
   localparam logic ETC_SEL_NONSEC = 1'h1;

   typedef logic signed [3:0] etc_prio_t;

   localparam etc_prio_t ETC_PRIO_SHF    = -4'sh3;
   localparam etc_prio_t ETC_PRIO_NMI    = -4'sh2;
   localparam etc_prio_t ETC_PRIO_HF     = -4'sh1;
   localparam etc_prio_t ETC_PRIO_CFG    = 4'sh0;
   localparam etc_prio_t ETC_PRIO_THREAD = 4'sh1;

   localparam logic [7:0] ETC_EXC_NMI  = 8'h02;
   localparam logic [7:0] ETC_EXC_HF   = 8'h03;
   localparam logic [7:0] ETC_EXC_SUP  = 8'h0B;
   localparam logic [7:0] ETC_EXC_PSV  = 8'h0E;
   localparam logic [7:0] ETC_EXC_TCK  = 8'h0F;
   localparam logic [7:0] ETC_EXC_IRQ0 = 8'h10;

   // Byte offset of the reset entry in the vector table.
   localparam logic [7:0] ETC_RESET_VEC_OFF = 8'h04;

   typedef enum logic [1:0] {
      ETC_HALT,
      ETC_BOOT,
      ETC_RUN
   } etc_boot_t;

   typedef struct packed {
      logic valid;
      logic secure_origin;
      logic bus_fault;
   } etc_fault_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] excnum;
      logic       exc_secure;
      logic       back_secure;
   } etc_ret_t;

   typedef struct packed {
      logic [7:0] excnum;
      logic       secure;
      etc_prio_t  prio;
   } etc_take_t;

   typedef struct packed {
      logic       halt;
      logic       boot_fetch;
      logic [7:0] vec_off;
      logic       secure;
      logic       privileged;
      logic       handler;
   } etc_core_t;

endpackage

// ### etc_exception_ctrl_properties.sv
module etc_exc_props
   import etc_pkg::*;
#(
   parameter int N_IRQ = 32
) (
   input wire logic             mclk_i,
   input wire logic             reset_i,
   input wire logic             fault_nmi_nonsecure_select_i,
   input wire etc_fault_t       fault_i,
   input wire logic [N_IRQ-1:0] irq_i,
   input wire logic             take_ready_i,
   input wire etc_ret_t         ret_i,
   input wire logic             take_valid_o,
   input wire etc_take_t        take_o,
   input wire etc_core_t        core_o,
   input wire logic [N_IRQ+8:0] pending_o,
   input wire logic [N_IRQ+8:0] active_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_enter;
      take_valid_o && take_ready_i;
   endsequence
   sequence s_boot;
      core_o.boot_fetch && core_o.secure && core_o.privileged && !core_o.handler
         && core_o.vec_off == ETC_RESET_VEC_OFF;
   endsequence

   // Reset is the one place where the checker must keep watching.
   AST_HALT:
   assert property (disable iff (1'b0) reset_i |-> core_o.halt && !take_valid_o)
      else $error("core runs during reset");
   AST_BOOT:
   assert property ($fell(reset_i) |=> s_boot) else $error("no boot fetch after reset");
   AST_BOOT_QUIET:
   assert property (core_o.boot_fetch |-> !take_valid_o) else $error("entry during boot");
   AST_IRQ_PEND:
   assert property (irq_i[0] |=> pending_o[ETC_SL_IRQ0]) else $error("interrupt not pending");
   AST_ENTRY:
   assert property (s_enter |=> !take_valid_o && active_o != '0) else $error("entry not taken");
   AST_NMI_BANK:
   assert property (take_valid_o && take_o.excnum == ETC_EXC_NMI
      |-> take_o.secure != fault_nmi_nonsecure_select_i && take_o.prio == ETC_PRIO_NMI)
      else $error("wrong NMI state");
   AST_SHF_PRIO:
   assert property (take_valid_o && take_o.excnum == ETC_EXC_HF && take_o.secure
      |-> take_o.prio == (fault_nmi_nonsecure_select_i ? ETC_PRIO_SHF : ETC_PRIO_HF))
      else $error("wrong secure fault priority");
   AST_FAULT_SEL0:
   assert property (fault_i.valid && !fault_nmi_nonsecure_select_i |=> pending_o[ETC_SL_HF_S])
      else $error("fault not routed to secure");
   AST_BUS_NS:
   assert property (fault_i.valid && fault_i.bus_fault && fault_nmi_nonsecure_select_i
      |=> pending_o[ETC_SL_HF_NS]) else $error("bus fault not non-secure");
   AST_RET_SHF:
   assert property (ret_i.valid && ret_i.excnum == ETC_EXC_HF && ret_i.exc_secure
      |=> !active_o[ETC_SL_HF_S]) else $error("return left fault active");
endmodule // etc_exc_props

// ### etc_pipe_model.sv
module etc_pipe_model
   import etc_pkg::*;
(
   // Clock and reset.
   input  wire logic      mclk_i,
   input  wire logic      reset_i,
   // Core side.
   input  wire etc_core_t core_i,
   input  wire logic      offer_i,
   input  wire logic      go_i,
   output logic           boot_done_o,
   output logic           take_ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // The vector fetch costs one cycle, like a slow memory would.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         boot_done_o <= 1'b0;
      end else begin
         boot_done_o <= core_i.boot_fetch && !boot_done_o;
      end
   end
   assign take_ready_o = offer_i && go_i;
endmodule // etc_pipe_model

// ### testbench.sv
module testbench
   import etc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NI = 8;
   localparam int NP = NI + 9;
   logic mclk_i, reset_i, sel, itns_we, nmi_p, nmi_s, sup, go, boot_done, ready, tv;
   logic [NI-1:0] itns, irq, irq_s, itns_o;
   logic [1:0]    psv, tz, ts;
   logic [NP-1:0] pend, act;
   etc_fault_t    flt;
   etc_ret_t      ret;
   etc_take_t     take;
   etc_core_t     core;
   int            n_fail = 0;
   int            n_tests = 0;

   etc_exception_ctrl #(.N_IRQ(NI)) dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
      .fault_nmi_nonsecure_select_i(sel), .irq_target_we_i(itns_we), .irq_target_ns_i(itns),
      .nmi_periph_i(nmi_p), .nmi_soft_i(nmi_s), .fault_i(flt), .supervisor_call_i(sup),
      .pendable_service_request_i(psv), .tick_zero_i(tz), .tick_soft_i(ts), .irq_i(irq),
      .irq_soft_i(irq_s), .boot_done_i(boot_done), .take_ready_i(ready), .ret_i(ret),
      .take_valid_o(tv), .take_o(take), .core_o(core), .irq_target_ns_o(itns_o),
      .pending_o(pend), .active_o(act));
   etc_pipe_model pipe_u (.mclk_i(mclk_i), .reset_i(reset_i), .core_i(core), .offer_i(tv),
      .go_i(go), .boot_done_o(boot_done), .take_ready_o(ready));

   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n = 1);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic clear_in();
      {nmi_p, nmi_s, sup, itns_we, irq, irq_s, psv, tz, ts, flt, ret, itns} = '0;
   endtask
   task automatic accept();
      chk(tv, 1'b1);
      go = 1'b1;
      step();
      go = 1'b0;
      chk(tv, 1'b0);
   endtask
   task automatic do_reset();
      reset_i = 1'b1;
      #1;
      chk({core.halt, tv, pend}, 1 << (NP + 1));
      step(20);
      reset_i = 1'b0;
      step();
      chk(core, {1'b0, 1'b1, ETC_RESET_VEC_OFF, 1'b1, 1'b1, 1'b0});
      chk(itns_o, 8'h00);
      repeat (8) if (core.boot_fetch === 1'b1) step();
      chk(core.boot_fetch, 1'b0);
   endtask
   task automatic t_irq();
      itns = 8'h01;
      itns_we = 1'b1;
      step();
      clear_in();
      chk(itns_o, 8'h01);
      irq[0] = 1'b1;
      step();
      clear_in();
      chk(pend, 1 << ETC_SL_IRQ0);
      step();
      chk(take, {ETC_EXC_IRQ0, 1'b0, ETC_PRIO_CFG});
      accept();
      chk({pend, act, core.secure}, 1 << (ETC_SL_IRQ0 + 1));
      chk(core.handler, 1'b1);
      // Non-secure handler: the call lands in its own bank, retargeting is ignored.
      ret = '{1'b1, ETC_EXC_IRQ0, 1'b0, 1'b1};
      sup = 1'b1;
      itns = 8'hFF;
      itns_we = 1'b1;
      step();
      clear_in();
      chk({act, core.secure}, 1);
      chk(pend, 1 << ETC_SL_SUP_N);
      chk(itns_o, 8'h01);
   endtask
   task automatic t_prio();
      do_reset();
      sel = ETC_SEL_NONSEC;
      irq_s[0] = 1'b1;
      tz[1] = 1'b1;
      nmi_p = 1'b1;
      step(); clear_in(); step();
      chk(take, {ETC_EXC_NMI, 1'b0, ETC_PRIO_NMI});
      flt = '{1'b1, 1'b1, 1'b0};
      step(); clear_in(); step();
      chk(take, {ETC_EXC_HF, 1'b1, ETC_PRIO_SHF});
      accept();
      step(3);
      chk(tv, 1'b0);
      ret = '{1'b1, ETC_EXC_HF, 1'b1, 1'b1};
      step(); clear_in(); step();
      chk(take.excnum, ETC_EXC_NMI);
      accept();
      ret = '{1'b1, ETC_EXC_NMI, 1'b0, 1'b1};
      step(); clear_in(); step();
      chk(take, {ETC_EXC_TCK, 1'b1, ETC_PRIO_CFG});
   endtask
   task automatic t_route();
      do_reset();
      sel = ETC_SEL_SECURE;
      flt = '{1'b1, 1'b0, 1'b1};
      step(); clear_in();
      chk(pend, 1 << ETC_SL_HF_S);
      step();
      chk(take, {ETC_EXC_HF, 1'b1, ETC_PRIO_HF});
      nmi_s = 1'b1;
      step(); clear_in(); step();
      chk(take, {ETC_EXC_NMI, 1'b1, ETC_PRIO_NMI});
      do_reset();
      sel = ETC_SEL_NONSEC;
      flt = '{1'b1, 1'b1, 1'b1};
      step(); clear_in();
      chk(pend, 1 << ETC_SL_HF_NS);
   endtask
   task automatic t_bank();
      do_reset();
      psv = 2'b11;
      ts = 2'b01;
      sup = 1'b1;
      irq_s[NI-1] = 1'b1;
      step(); clear_in();
      chk(pend, 17'h1_0168);
      step();
      chk(take, {ETC_EXC_SUP, 1'b1, ETC_PRIO_CFG});
   endtask

   initial begin
      clear_in();
      go = 1'b0;
      sel = ETC_SEL_SECURE;
      do_reset();
      t_irq();
      t_prio();
      t_route();
      t_bank();
      print_verdict();
   end
   // Whole run is under two hundred cycles, so this only trips on a hang.
   initial begin
      repeat (3000) @(posedge mclk_i);
      n_fail++;
      print_verdict();
   end
endmodule // testbench

bind etc_exception_ctrl etc_exc_props #(.N_IRQ(N_IRQ)) prop_u (.mclk_i(mclk_i),
   .reset_i(reset_i), .fault_nmi_nonsecure_select_i(fault_nmi_nonsecure_select_i),
   .fault_i(fault_i), .irq_i(irq_i), .take_ready_i(take_ready_i), .ret_i(ret_i),
   .take_valid_o(take_valid_o), .take_o(take_o), .core_o(core_o),
   .pending_o(pending_o), .active_o(active_o));
